/* core/psm_phy_regs.sv */
// PHY symbol error counter and special control register bank with AXI4-Lite access
//
// Notes on behaviour
// - Invalid 100BASE-TX symbol, idle included, increments counter
// - Counter advances at most once per packet
// - Counter wraps to zero past maximum
// - Counter resets to zero; read does not clear
// - Counter holds in 10BASE-T mode
// - Source select one: register bits decide crossover
// - Source select zero (reset): straps decide crossover
// - Register pairs give straight, crossover, auto; one reserved
// - Auto strap wins, else manual strap decides
// - Heartbeat disable defaults zero; one disables test
// - Far-end fault bit enables generation and detection
// - Far-end fault resets to fiber mode strap
// - PHY reset returns clearable control bits to defaults
`timescale 1ns/1ps
module psm_phy_regs
    import psm_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              srst,
    // AXI4-Lite write
    input  wire logic [PSM_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [PSM_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Strap pins and receive events
    input  wire psm_strap_s        strap_pins,
    input  wire psm_rx_s           rx_evt,
    // PHY controls
    output psm_mdix_e              mdix_mode,
    output logic                   heartbeat_test_disable,
    output logic                   far_end_fault_enable,
    output logic                   phy_reset_pulse
);

    // ============================================================
    // Strap synchroniser
    psm_strap_s strap_s1_r;
    psm_strap_s strap_s2_r;

    always_ff @(posedge clock) begin
        strap_s1_r <= strap_pins;
        strap_s2_r <= strap_s1_r;
    end

    // ============================================================
    // Symbol error counter
    wire logic [15:0] symerr_count;

    psm_symerr_counter u_symerr (
        .clock  (clock),
        .srst   (srst),
        .rx_evt (rx_evt),
        .count  (symerr_count)
    );

    // ============================================================
    // Write channel
    logic              awready_r;
    logic              wready_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic [PSM_AW-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;

    wire logic aw_take = s_axi_awvalid && awready_r;
    wire logic w_take  = s_axi_wvalid && wready_r;
    wire logic b_done  = bvalid_r && s_axi_bready;
    wire logic commit  = aw_held_r && w_held_r && !bvalid_r;

    wire logic wr_spctl  = commit && psm_hit(aw_addr_r, PSM_IDX_SPCTL);
    wire logic wr_rstctl = commit && psm_hit(aw_addr_r, PSM_IDX_RSTCTL);
    wire logic wr_known  = psm_hit(aw_addr_r, PSM_IDX_SYMERR) || psm_hit(aw_addr_r, PSM_IDX_SPCTL)
                         || psm_hit(aw_addr_r, PSM_IDX_RSTCTL) || psm_hit(aw_addr_r, PSM_IDX_STATUS);
    wire logic wr_hi     = wr_spctl && w_strb_r[1];
    wire logic wr_lo     = wr_spctl && w_strb_r[0];

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // Address and data are taken in either order; no new one until the response goes
    always_ff @(posedge clock) begin
        if (srst) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= PSM_RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                awready_r <= 1'b0;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                wready_r <= 1'b0;
            end
            if (commit) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_known ? PSM_RESP_OKAY : PSM_RESP_SLV;
            end
            if (b_done) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // ============================================================
    // Chip reset control and special control bits
    logic       phy_rst_r;
    logic       xsrc_r;
    logic       xen_r;
    logic       xstate_r;
    logic       hboff_r;
    logic       fef_r;
    logic [1:0] fef_pend_r;

    // Clearable bits go back to defaults on the PHY reset; far-end fault is not clearable
    wire logic phy_reset_clearable_clr = phy_rst_r;
    wire logic fef_load = fef_pend_r == 2'h1;

    always_ff @(posedge clock) begin
        if (srst) begin
            phy_rst_r <= 1'b0;
        end else begin
            phy_rst_r <= wr_rstctl && w_strb_r[0] && w_data_r[PSM_B_PHYRST];
        end
    end

    always_ff @(posedge clock) begin
        if (srst || phy_reset_clearable_clr) begin
            xsrc_r   <= PSM_CTL_RST;
            xen_r    <= PSM_CTL_RST;
            xstate_r <= PSM_CTL_RST;
            hboff_r  <= PSM_CTL_RST;
        end else if (wr_hi) begin
            xsrc_r   <= w_data_r[PSM_B_XSRC];
            xen_r    <= w_data_r[PSM_B_XEN];
            xstate_r <= w_data_r[PSM_B_XSTATE];
            hboff_r  <= w_data_r[PSM_B_HBOFF];
        end
    end

    // Strap is sampled only once it has crossed the synchroniser after reset
    always_ff @(posedge clock) begin
        if (srst) begin
            fef_r      <= 1'b0;
            fef_pend_r <= PSM_FEF_LOAD;
        end else begin
            if (fef_pend_r != 2'h0) begin
                fef_pend_r <= fef_pend_r - 2'h1;
            end
            if (fef_load) begin
                fef_r <= strap_s2_r.fx_mode;
            end else if (wr_lo) begin
                fef_r <= w_data_r[PSM_B_FEF];
            end
        end
    end

    // ============================================================
    // Crossover resolution
    // The reserved register pair falls back to straight so the line never floats
    wire logic      reg_resv  = xen_r && xstate_r;
    wire psm_mdix_e reg_mode  = xen_r ? (xstate_r ? PSM_STRAIGHT : PSM_AUTO)
                                      : (xstate_r ? PSM_CROSS : PSM_STRAIGHT);
    wire psm_mdix_e strap_mode = strap_s2_r.auto_mdix ? PSM_AUTO
                               : (strap_s2_r.manual_mdix ? PSM_CROSS : PSM_STRAIGHT);
    wire psm_mdix_e mode_nxt  = xsrc_r ? reg_mode : strap_mode;

    psm_mdix_e mdix_mode_r;
    logic      hb_out_r;
    logic      fef_out_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            mdix_mode_r <= PSM_STRAIGHT;
            hb_out_r    <= 1'b0;
            fef_out_r   <= 1'b0;
        end else begin
            mdix_mode_r <= mode_nxt;
            hb_out_r    <= hboff_r;
            fef_out_r   <= fef_r;
        end
    end

    assign mdix_mode              = mdix_mode_r;
    assign heartbeat_test_disable = hb_out_r;
    assign far_end_fault_enable   = fef_out_r;
    assign phy_reset_pulse        = phy_rst_r;

    // ============================================================
    // Read channel
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    wire logic ar_take = s_axi_arvalid && arready_r;
    wire logic r_done  = rvalid_r && s_axi_rready;

    // Reserved bits 12 and 10..6 are simply never placed in the word
    wire logic [15:0] spctl_word = {xsrc_r, xen_r, xstate_r, 1'b0, hboff_r,
                                    5'h00, fef_r, 5'h00};
    wire logic [15:0] status_word = {10'h000, strap_s2_r.manual_mdix, strap_s2_r.auto_mdix,
                                     strap_s2_r.fx_mode, reg_resv, mdix_mode_r};
    wire logic rd_sym = psm_hit(s_axi_araddr, PSM_IDX_SYMERR);
    wire logic rd_spc = psm_hit(s_axi_araddr, PSM_IDX_SPCTL);
    wire logic rd_rst = psm_hit(s_axi_araddr, PSM_IDX_RSTCTL);
    wire logic rd_sts = psm_hit(s_axi_araddr, PSM_IDX_STATUS);
    wire logic [15:0] rd_word = rd_sym ? symerr_count
                              : rd_spc ? spctl_word
                              : rd_sts ? status_word : 16'h0000;
    wire logic rd_ok = rd_sym || rd_spc || rd_rst || rd_sts;

    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= PSM_RESP_OKAY;
        end else begin
            if (ar_take) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= {16'h0000, rd_word};
                rresp_r   <= rd_ok ? PSM_RESP_OKAY : PSM_RESP_SLV;
            end
            if (r_done) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ============================================================
    // Checks
    property p_strap_auto;
        @(posedge clock) disable iff (srst)
        (!xsrc_r && strap_s2_r.auto_mdix) |=> mdix_mode_r == PSM_AUTO;
    endproperty
    a_strap_auto: assert property (p_strap_auto) else $error("auto strap ignored");

    property p_strap_man;
        @(posedge clock) disable iff (srst)
        (!xsrc_r && !strap_s2_r.auto_mdix) |=>
            mdix_mode_r == ($past(strap_s2_r.manual_mdix) ? PSM_CROSS : PSM_STRAIGHT);
    endproperty
    a_strap_man: assert property (p_strap_man) else $error("manual strap ignored");

    property p_reg_ctl;
        @(posedge clock) disable iff (srst)
        (xsrc_r && !xen_r) |=> mdix_mode_r == ($past(xstate_r) ? PSM_CROSS : PSM_STRAIGHT);
    endproperty
    a_reg_ctl: assert property (p_reg_ctl) else $error("register crossover ignored");

    property p_reg_auto;
        @(posedge clock) disable iff (srst)
        (xsrc_r && xen_r && !xstate_r) |=> mdix_mode_r == PSM_AUTO;
    endproperty
    a_reg_auto: assert property (p_reg_auto) else $error("register auto not taken");

    sequence s_phy_rst_wr;
        wr_rstctl && w_strb_r[0] && w_data_r[PSM_B_PHYRST];
    endsequence
    property p_phy_rst;
        @(posedge clock) disable iff (srst)
        s_phy_rst_wr |=> ##1 (!xsrc_r && !xen_r && !xstate_r && !hboff_r && $stable(fef_r));
    endproperty
    a_phy_rst: assert property (p_phy_rst) else $error("PHY reset did not clear bits");

    property p_hb_write;
        @(posedge clock) disable iff (srst)
        wr_hi |=> ##1 heartbeat_test_disable == $past(w_data_r[PSM_B_HBOFF], 2);
    endproperty
    a_hb_write: assert property (p_hb_write) else $error("heartbeat bit not applied");

    property p_fef_strap;
        @(posedge clock) disable iff (srst)
        fef_load |=> fef_r == $past(strap_s2_r.fx_mode);
    endproperty
    a_fef_strap: assert property (p_fef_strap) else $error("far-end default wrong");

    property p_resv_zero;
        @(posedge clock) disable iff (srst)
        (ar_take && rd_spc) |=> (rdata_r[12] == 1'b0 && rdata_r[10:6] == 5'h00);
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");

    property p_rd_noclr;
        @(posedge clock) disable iff (srst)
        (ar_take && rd_sym && !rx_evt.sym_err) |=>
            (symerr_count == $past(symerr_count) && rdata_r[15:0] == $past(symerr_count));
    endproperty
    a_rd_noclr: assert property (p_rd_noclr) else $error("read cleared counter");

    property p_wr_resp;
        @(posedge clock) disable iff (srst)
        commit |=> bvalid_r ##0 (!bvalid_r || !awready_r)[*1];
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

endmodule

/* core/psm_pkg.sv */
// Package: map, fields, reset values and types of the symbol error / crossover block
package psm_pkg;

    // ============================================================
    // Register indices (byte address is four times the index)
    localparam int          PSM_AW         = 10;
    localparam logic [7:0]  PSM_IDX_SYMERR = 8'h1a;
    localparam logic [7:0]  PSM_IDX_SPCTL  = 8'h1b;
    localparam logic [7:0]  PSM_IDX_RSTCTL = 8'h20;
    localparam logic [7:0]  PSM_IDX_STATUS = 8'h21;

    // ============================================================
    // Field positions
    localparam int          PSM_B_XSRC     = 15;
    localparam int          PSM_B_XEN      = 14;
    localparam int          PSM_B_XSTATE   = 13;
    localparam int          PSM_B_HBOFF    = 11;
    localparam int          PSM_B_FEF      = 5;
    localparam int          PSM_B_PHYRST   = 0;

    // ============================================================
    // Reset values and counts
    localparam logic [15:0] PSM_SYMERR_RST = 16'h0000;
    localparam logic        PSM_CTL_RST    = 1'b0;
    localparam logic [1:0]  PSM_FEF_LOAD   = 2'h3;
    localparam logic [1:0]  PSM_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  PSM_RESP_SLV   = 2'h2;

    // ============================================================
    // Types
    typedef enum logic [1:0] {
        PSM_STRAIGHT,
        PSM_CROSS,
        PSM_AUTO
    } psm_mdix_e;

    typedef struct packed {
        logic auto_mdix;
        logic manual_mdix;
        logic fx_mode;
    } psm_strap_s;

    typedef struct packed {
        logic in_packet;
        logic sym_err;
        logic speed_10;
    } psm_rx_s;

    function automatic logic psm_hit(input logic [PSM_AW-1:0] a, input logic [7:0] idx);
        return a[PSM_AW-1:2] == idx;
    endfunction

endpackage

/* core/psm_symerr_counter.sv */
// Receive symbol error counter, once per packet, wrapping
`timescale 1ns/1ps
module psm_symerr_counter
    import psm_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // Receive events
    input  wire psm_rx_s     rx_evt,
    // Count
    output logic      [15:0] count
);

    // ============================================================
    // Counting
    logic        counted_r;
    logic [15:0] count_r;
    wire  logic  inc;
    wire  logic  blocked;

    // A packet that already counted blocks further errors until it ends
    assign blocked = rx_evt.in_packet && counted_r;
    assign inc     = rx_evt.sym_err && !rx_evt.speed_10 && !blocked;
    assign count   = count_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            count_r   <= PSM_SYMERR_RST;
            counted_r <= 1'b0;
        end else begin
            if (inc) begin
                count_r <= count_r + 16'h0001;
            end
            counted_r <= rx_evt.in_packet && (counted_r || inc);
        end
    end

    // ============================================================
    // Checks
    property p_wrap;
        @(posedge clock) disable iff (srst)
        (inc && count_r == 16'hffff) |=> count_r == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

    property p_hold10;
        @(posedge clock) disable iff (srst)
        rx_evt.speed_10 |=> $stable(count_r);
    endproperty
    a_hold10: assert property (p_hold10) else $error("count moved in 10 Mb mode");

    sequence s_counted;
        rx_evt.in_packet && counted_r;
    endsequence
    property p_once;
        @(posedge clock) disable iff (srst)
        s_counted |=> $stable(count_r);
    endproperty
    a_once: assert property (p_once) else $error("second count in one packet");

    property p_inc;
        @(posedge clock) disable iff (srst)
        inc |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("invalid symbol not counted");

endmodule

/* tb/psm_phy_regs_test.sv */
// Self-checking bench for the PHY symbol error counter and special control bank
`timescale 1ns/1ps
module psm_phy_regs_test
    import psm_pkg::*;
;
    // ============================================================
    // Signals and addresses
    localparam logic [PSM_AW-1:0] A_SYMERR = {PSM_IDX_SYMERR, 2'b00};
    localparam logic [PSM_AW-1:0] A_SPCTL  = {PSM_IDX_SPCTL, 2'b00};
    localparam logic [PSM_AW-1:0] A_RSTCTL = {PSM_IDX_RSTCTL, 2'b00};
    localparam logic [PSM_AW-1:0] A_STATUS = {PSM_IDX_STATUS, 2'b00};
    localparam logic [PSM_AW-1:0] A_BAD    = 10'h100;
    localparam logic [1:0]        OK       = PSM_RESP_OKAY;

    logic              clock;
    logic              srst;
    logic [PSM_AW-1:0] awaddr;
    logic [PSM_AW-1:0] araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    psm_strap_s        strap;
    psm_rx_s           rx;
    psm_mdix_e         mdix_mode;
    logic              hb;
    logic              fef;
    logic              rst_pulse;
    int                n_mismatch = 0;
    int                total_checks = 0;
    int                n_pulse = 0;

    psm_phy_regs dut (
        .clock(clock), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .strap_pins(strap), .rx_evt(rx), .mdix_mode(mdix_mode),
        .heartbeat_test_disable(hb), .far_end_fault_enable(fef), .phy_reset_pulse(rst_pulse)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Pulse is only one cycle wide, so count it at every edge
    always @(posedge clock) begin
        if (rst_pulse === 1'b1) begin
            n_pulse <= n_pulse + 1;
        end
    end

    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [PSM_AW-1:0] a, input logic [15:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge clock);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {16'h0000, d};
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [PSM_AW-1:0] a, input logic [1:0] er, input logic [15:0] ed);
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check({30'h0, rresp}, {30'h0, er});
        if (er === OK) begin
            check(rdata, {16'h0000, ed});
        end
    endtask

    // Holds sym_err high for n sampling edges
    task automatic rx_burst(input logic pkt, input logic s10, input int n);
        @(posedge clock);
        rx <= '{pkt, 1'b1, s10};
        repeat (n) @(posedge clock);
        rx <= '{1'b0, 1'b0, 1'b0};
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        axi_rd(A_SYMERR, OK, 16'h0000);
        axi_rd(A_SPCTL, OK, 16'h0000);
        check({30'h0, mdix_mode}, {30'h0, PSM_CROSS});
        check({31'h0, hb}, 32'h0000_0000);
        check({31'h0, fef}, 32'h0000_0000);
    endtask

    task automatic t_counter();
        rx_burst(1'b0, 1'b0, 2);
        axi_rd(A_SYMERR, OK, 16'h0002);
        rx_burst(1'b1, 1'b0, 3);
        axi_rd(A_SYMERR, OK, 16'h0003);
        rx_burst(1'b0, 1'b1, 4);
        axi_rd(A_SYMERR, OK, 16'h0003);
        axi_wr(A_SYMERR, 16'hffff, 4'h3, OK);
        axi_rd(A_SYMERR, OK, 16'h0003);
        rx_burst(1'b0, 1'b0, 65532);
        axi_rd(A_SYMERR, OK, 16'hffff);
        rx_burst(1'b0, 1'b0, 1);
        axi_rd(A_SYMERR, OK, 16'h0000);
    endtask

    task automatic t_xreg();
        psm_mdix_e exp_mode [4] = '{PSM_STRAIGHT, PSM_CROSS, PSM_AUTO, PSM_STRAIGHT};
        // Copper port, so the auto pair is a legal setting here
        for (int i = 0; i < 4; i++) begin
            axi_wr(A_SPCTL, 16'h8000 | (16'(i) << 13), 4'h3, OK);
            repeat (3) @(posedge clock);
            check({30'h0, mdix_mode}, {30'h0, exp_mode[i]});
        end
    endtask

    task automatic t_xstrap();
        // Register pair says auto, but with source zero it must be ignored
        axi_wr(A_SPCTL, 16'h4000, 4'h3, OK);
        for (int j = 0; j < 4; j++) begin
            @(posedge clock);
            strap <= '{j[1], j[0], 1'b0};
            repeat (5) @(posedge clock);
            check({30'h0, mdix_mode}, {30'h0, j[1] ? PSM_AUTO : (j[0] ? PSM_CROSS : PSM_STRAIGHT)});
        end
    endtask

    task automatic t_bits();
        axi_wr(A_SPCTL, 16'hffff, 4'h3, OK);
        axi_rd(A_SPCTL, OK, 16'he820);
        axi_rd(A_STATUS, OK, 16'h0034);
        check({31'h0, hb}, 32'h0000_0001);
        check({31'h0, fef}, 32'h0000_0001);
        check({30'h0, mdix_mode}, {30'h0, PSM_STRAIGHT});
        axi_wr(A_SPCTL, 16'h0000, 4'h3, OK);
        repeat (3) @(posedge clock);
        check({31'h0, fef}, 32'h0000_0000);
        check({31'h0, hb}, 32'h0000_0000);
    endtask

    task automatic t_phyrst();
        int n0;
        axi_wr(A_SPCTL, 16'ha820, 4'h3, OK);
        n0 = n_pulse;
        axi_wr(A_RSTCTL, 16'h0001, 4'h1, OK);
        repeat (3) @(posedge clock);
        check(n_pulse - n0, 32'h0000_0001);
        axi_rd(A_RSTCTL, OK, 16'h0000);
        axi_rd(A_SPCTL, OK, 16'h0020);
        check({31'h0, hb}, 32'h0000_0000);
        check({30'h0, mdix_mode}, {30'h0, PSM_AUTO});
        axi_wr(A_BAD, 16'h1234, 4'h3, PSM_RESP_SLV);
        axi_rd(A_BAD, PSM_RESP_SLV, 16'h0000);
    endtask

    task automatic t_srst();
        rx_burst(1'b0, 1'b0, 1);
        axi_rd(A_SYMERR, OK, 16'h0001);
        @(posedge clock);
        strap <= '{1'b0, 1'b0, 1'b1};
        repeat (4) @(posedge clock);
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        repeat (6) @(posedge clock);
        axi_rd(A_SYMERR, OK, 16'h0000);
        axi_rd(A_SPCTL, OK, 16'h0020);
        check({31'h0, fef}, 32'h0000_0001);
        check({30'h0, mdix_mode}, {30'h0, PSM_STRAIGHT});
    endtask

    // ============================================================
    // Main sequence and watchdog
    initial begin
        srst    = 1'b1;
        awaddr  = '0;
        araddr  = '0;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        arvalid = 1'b0;
        rready  = 1'b0;
        wdata   = 32'h0000_0000;
        wstrb   = 4'h0;
        strap   = '{1'b0, 1'b1, 1'b0};
        rx      = '{1'b0, 1'b0, 1'b0};
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        repeat (6) @(posedge clock);
        t_reset();
        t_counter();
        t_xreg();
        t_xstrap();
        t_bits();
        t_phyrst();
        t_srst();
        finish_test();
    end

    // Whole run is about 66000 cycles; this margin only trips on a hang
    initial begin
        repeat (90000) @(posedge clock);
        n_mismatch++;
        finish_test();
    end
endmodule
